// [common/bcctr_cfg.svh]
// constants for the count-register branch decoder
`ifndef BCCTR_CFG_SVH
`define BCCTR_CFG_SVH
`define BCCTR_PRIMARY_OP 6'h13
`define BCCTR_EXTENDED_OP 10'h210
`define BCCTR_INSTR_STEP 32'h0000_0004
`define BCCTR_OPT_BRANCH_SET 5'h0C
`define BCCTR_OPT_BRANCH_CLEAR 5'h04
`endif

// [common/bcctr_pkg.sv]
// types for the count-register branch decoder
package bcctr_pkg;
  typedef struct packed {
    logic [5:0] primaryOp;
    logic [4:0] branchOptionsField;
    logic [4:0] conditionBitIndex;
    logic [4:0] unusedField;
    logic [9:0] extendedOp;
    logic linkFlag;
  } bcctr_instr_type;
  typedef struct packed {
    logic hit;
    logic taken;
    logic invalidForm;
    logic predictHint;
  } bcctr_eval_type;
endpackage : bcctr_pkg

// [common/bcctr_if.sv]
// decode result carried from evaluator to the top
`timescale 1ns/1ps
interface bcctr_if;
  import bcctr_pkg::*;
  bcctr_instr_type instr;
  logic [31:0] conditionRegister;
  bcctr_eval_type result;
  modport evaluator (input instr, input conditionRegister, output result);
  modport user (output instr, output conditionRegister, input result);
endinterface : bcctr_if

// [core/bcctr_eval.sv]
// combinational decode and condition evaluation
`timescale 1ns/1ps
`include "bcctr_cfg.svh"
module bcctr_eval
(
  bcctr_if.evaluator bus
);
  import bcctr_pkg::*;
  // bit 0 of the printed word order is our msb
  function automatic logic condBit(input logic [31:0] cr, input logic [4:0] idx);
    condBit = cr[5'h1F - idx];
  endfunction : condBit

  logic [4:0] opts;
  assign opts = bus.instr.branchOptionsField;
  always_comb
  begin
    bus.result.hit = (bus.instr.primaryOp == `BCCTR_PRIMARY_OP) &&
                     (bus.instr.extendedOp == `BCCTR_EXTENDED_OP);
    // opts[4] is printed bit 0; unconditional when set, index ignored
    bus.result.taken = opts[4] ||
                       (condBit(bus.conditionRegister, bus.instr.conditionBitIndex) == opts[3]);
    bus.result.invalidForm = ~opts[2];
    bus.result.predictHint = opts[0];
  end
endmodule : bcctr_eval

// [core/bcctr_top.sv]
// count-register branch: next address and link update
//
// Contract
// - Opcode 19 in bits 0-5 and 528 in bits 21-30 select the branch; options 6-10, index 11-15, link bit 31.
// - With options bit 0 clear, the indexed condition bit must equal options bit 1 for a taken branch.
// - With options bit 0 set, the branch is taken and the condition register is not consulted.
// - A taken branch targets the upper 30 count-register bits with two zero bits appended.
// - A not-taken branch continues at the current address plus 4.
// - With the link flag set, current address plus 4 is written to the link register, taken or not.
// - Options bit 4 is only a prediction hint and never changes outcome or target.
// - Options 12 branch on a set bit and 4 on a clear bit, neither touching the count register.
// - Condition bit number is four times the field number plus 0 lt, 1 gt, 2 eq, 3 so/un.
// - Unordered and summary-overflow forms both test offset 3 of the field.
`timescale 1ns/1ps
`include "bcctr_cfg.svh"
module bcctr_top
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic [31:0] conditionRegister,
  input wire logic [31:0] countRegister,
  input wire logic [31:0] currentInstrAddress,
  output logic resultValid_r,
  output logic branchHit_r,
  output logic branchTaken_r,
  output logic [31:0] nextInstrAddress_r,
  output logic linkWrite_r,
  output logic [31:0] linkRegisterData_r,
  output logic predictHint_r,
  output logic invalidForm_r
);
  import bcctr_pkg::*;

  // ==========================================
  // evaluation
  bcctr_if evalBus ();
  assign evalBus.instr = bcctr_instr_type'(instrWord);
  assign evalBus.conditionRegister = conditionRegister;
  bcctr_eval uEval
  (
    .bus(evalBus.evaluator)
  );

  logic [31:0] seqAddr;
  logic [31:0] targetAddr;
  logic fire;
  assign seqAddr = currentInstrAddress + `BCCTR_INSTR_STEP;
  assign targetAddr = {countRegister[31:2], 2'b00};
  assign fire = instrValid && evalBus.result.hit;

  // ==========================================
  // result registers; the count register is only read, never driven
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resultValid_r <= 1'b0;
      branchHit_r <= 1'b0;
      branchTaken_r <= 1'b0;
      nextInstrAddress_r <= 32'h0000_0000;
      predictHint_r <= 1'b0;
      invalidForm_r <= 1'b0;
    end
    else if (clkEn)
    begin
      resultValid_r <= instrValid;
      branchHit_r <= fire;
      branchTaken_r <= fire && evalBus.result.taken;
      nextInstrAddress_r <= (fire && evalBus.result.taken) ? targetAddr : seqAddr;
      predictHint_r <= fire && evalBus.result.predictHint;
      invalidForm_r <= fire && evalBus.result.invalidForm;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      linkWrite_r <= 1'b0;
      linkRegisterData_r <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      linkWrite_r <= fire && instrWord[0];
      if (fire && instrWord[0])
        linkRegisterData_r <= seqAddr;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);


  // bit number field*4+offset, counted from the msb of the condition word
  function automatic logic crBitAt(input logic [31:0] cr, input logic [2:0] field, input logic [1:0] offset);
    crBitAt = cr[5'h1F - {field, 2'b00} - {3'b000, offset}];
  endfunction : crBitAt

  // fields taken straight from the word, kept apart from the evaluator so the checks stay independent
  logic [4:0] optsNow;
  logic [4:0] indexNow;
  logic [2:0] fieldNow;
  logic [1:0] offsetNow;
  logic selBitNow;
  logic fieldBitNow;
  logic soBitNow;
  assign optsNow = instrWord[25:21];
  assign indexNow = instrWord[20:16];
  assign fieldNow = indexNow[4:2];
  assign offsetNow = indexNow[1:0];
  assign selBitNow = conditionRegister[5'h1F - indexNow];
  assign fieldBitNow = crBitAt(conditionRegister, fieldNow, offsetNow);
  assign soBitNow = crBitAt(conditionRegister, fieldNow, 2'b11);

  sequence firedS;
    clkEn && fire;
  endsequence

  sequence linkReqS;
    clkEn && fire && instrWord[0];
  endsequence

  sequence uncondS;
    clkEn && fire && optsNow[4];
  endsequence

  sequence setFormS;
    clkEn && fire && (optsNow == `BCCTR_OPT_BRANCH_SET);
  endsequence

  sequence clearFormS;
    clkEn && fire && (optsNow == `BCCTR_OPT_BRANCH_CLEAR);
  endsequence

  sequence overflowBitS;
    clkEn && fire && !optsNow[4] && (offsetNow == 2'b11);
  endsequence

  // ==========================================
  // address and link checks
  target_on_taken_a: assert property (
    firedS ##1 branchTaken_r |-> nextInstrAddress_r[1:0] == 2'b00)
    else $error("taken target not word aligned");
  target_value_a: assert property (
    firedS and evalBus.result.taken |=> nextInstrAddress_r == {$past(countRegister[31:2]), 2'b00})
    else $error("taken target differs from count register");
  fallthrough_a: assert property (
    clkEn && !(fire && evalBus.result.taken) |=> nextInstrAddress_r == $past(currentInstrAddress) + 32'h0000_0004)
    else $error("fallthrough address wrong");
  link_write_a: assert property (
    linkReqS |=> linkWrite_r && linkRegisterData_r == $past(currentInstrAddress) + 32'h0000_0004)
    else $error("link write missing");
  link_untaken_a: assert property (
    linkReqS and !evalBus.result.taken |=> linkWrite_r && linkRegisterData_r == $past(currentInstrAddress) + 32'h0000_0004)
    else $error("link skipped on a branch not taken");
  no_link_a: assert property (
    clkEn && !(fire && instrWord[0]) |=> !linkWrite_r)
    else $error("link written without flag");
  link_hold_a: assert property (
    clkEn && !(fire && instrWord[0]) |=> $stable(linkRegisterData_r))
    else $error("link data changed without flag");

  // ==========================================
  // decision checks
  uncond_take_a: assert property (
    firedS and instrWord[25] |=> branchTaken_r)
    else $error("unconditional branch not taken");
  uncond_target_a: assert property (
    uncondS |=> branchTaken_r && nextInstrAddress_r == {$past(countRegister[31:2]), 2'b00})
    else $error("unconditional branch went elsewhere");
  cond_match_a: assert property (
    firedS and !instrWord[25] |=> branchTaken_r == ($past(selBitNow) == $past(instrWord[24])))
    else $error("conditional decision wrong");
  set_form_a: assert property (
    setFormS |=> branchTaken_r == $past(selBitNow))
    else $error("set form decision wrong");
  clear_form_a: assert property (
    clearFormS |=> branchTaken_r == !$past(selBitNow))
    else $error("clear form decision wrong");
  field_offset_a: assert property (
    firedS and !optsNow[4] |=> branchTaken_r == ($past(fieldBitNow) == $past(optsNow[3])))
    else $error("field and offset select the wrong bit");
  so_bit_a: assert property (
    overflowBitS |=> branchTaken_r == ($past(soBitNow) == $past(optsNow[3])))
    else $error("offset three test wrong");
  hint_neutral_a: assert property (
    firedS |=> branchTaken_r == $past(evalBus.result.taken))
    else $error("decision disagrees with evaluator");
  hint_only_a: assert property (
    firedS |=> predictHint_r == $past(optsNow[0]))
    else $error("hint output wrong");
  hint_free_a: assert property (
    firedS |=> branchTaken_r == ($past(optsNow[4]) || ($past(selBitNow) == $past(optsNow[3]))))
    else $error("hint changed the decision");
  invalid_flag_a: assert property (
    firedS |=> invalidForm_r == !$past(optsNow[2]))
    else $error("invalid form flag wrong");

  // ==========================================
  // decode and pipeline checks
  decode_hit_a: assert property (
    clkEn && instrValid && instrWord[31:26] != `BCCTR_PRIMARY_OP |=> !branchHit_r)
    else $error("wrong opcode decoded as hit");
  ext_decode_a: assert property (
    clkEn && instrValid && instrWord[10:1] != `BCCTR_EXTENDED_OP |=> !branchHit_r)
    else $error("wrong extended opcode decoded as hit");
  hit_decode_a: assert property (
    firedS |=> branchHit_r)
    else $error("branch word not decoded as hit");
  idle_quiet_a: assert property (
    clkEn && !instrValid |=> !branchHit_r && !branchTaken_r && !linkWrite_r)
    else $error("result without a valid word");
  taken_hit_a: assert property (
    branchTaken_r |-> branchHit_r)
    else $error("taken without a hit");
  valid_follow_a: assert property (
    clkEn |=> resultValid_r == $past(instrValid))
    else $error("result valid does not follow the input");
  // a low enable must hold every result, including the link data
  freeze_a: assert property (
    !clkEn |=> $stable(nextInstrAddress_r) && $stable(branchTaken_r) && $stable(linkWrite_r) &&
      $stable(linkRegisterData_r) && $stable(resultValid_r))
    else $error("state moved while enable low");
endmodule : bcctr_top

// [verif/bcctr_pipe_model.sv]
// far-side pipeline model holding the link register
`timescale 1ns/1ps
module bcctr_pipe_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic linkWrite,
  input wire logic [31:0] linkData,
  output logic [31:0] linkRegister_r
);
  // ====================================
  // link register: only a write pulse or reset changes it
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      linkRegister_r <= 32'h0;
    else if (linkWrite)
      linkRegister_r <= linkData;
endmodule : bcctr_pipe_model

// [verif/tb_top.sv]
// self-checking bench for the count-register branch
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_b = 0, clkEn = 1, instrValid = 0;
  logic [31:0] instrWord = 0, cr = 0, ctr = 0, current_instr_address = 0, lr, next_instr_address, linkData;
  logic resultValid, hit, taken, linkWr, hint, invalid;
  int nErrors = 0, samplesChecked = 0, cycles = 0;
  // ====================================
  // clock, hang guard and design
  always #10 clk = ~clk;
  always @(posedge clk)
    if (++cycles == 3000)
    begin
      nErrors++;
      finishTest();
    end
  bcctr_top u_dut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .instrValid(instrValid), .instrWord(instrWord),
    .conditionRegister(cr), .countRegister(ctr), .currentInstrAddress(current_instr_address), .resultValid_r(resultValid),
    .branchHit_r(hit), .branchTaken_r(taken), .nextInstrAddress_r(next_instr_address), .linkWrite_r(linkWr),
    .linkRegisterData_r(linkData), .predictHint_r(hint), .invalidForm_r(invalid));
  bcctr_pipe_model u_pipe (.clk(clk), .rst_b(rst_b), .linkWrite(linkWr), .linkData(linkData), .linkRegister_r(lr));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // every options value keeps bit 2 set: the clear form is undefined
  task automatic issue(input logic [4:0] opt, input logic [4:0] bi, input logic lk, input logic [9:0] ext);
    instrWord = {6'h13, opt, bi, 5'h00, ext, lk};
    instrValid = 1;
    @(posedge clk);
    #1;
  endtask : issue
  task automatic runBranch(input logic [4:0] opt, input logic [4:0] bi, input logic lk);
    logic tk;
    tk = opt[4] | (cr[31 - bi] == opt[3]);
    issue(opt, bi, lk, 10'h210);
    check("hit", hit, 32'h1);
    check("valid", resultValid, 32'h1);
    check("taken", taken, tk);
    check("next", next_instr_address, tk ? {ctr[31:2], 2'h0} : current_instr_address + 32'h4);
    check("linkWrite", linkWr, lk);
    if (lk)
      check("linkData", linkData, current_instr_address + 32'h4);
    check("hint", hint, opt[0]);
    check("invalid", invalid, 32'h0);
  endtask : runBranch
  // ====================================
  // scenarios
  task automatic testUnconditional();
    cr = 32'hFFFF_FFFF;
    ctr = 32'h1234_5677;
    current_instr_address = 32'h0000_1000;
    runBranch(5'h14, 5'h1F, 1'h1);
    runBranch(5'h15, 5'h03, 1'h0);
  endtask : testUnconditional
  // all 32 condition bits, set and clear forms, back to back
  task automatic testConditional();
    cr = 32'hA5C3_0F96;
    ctr = 32'h8000_0102;
    for (int i = 0; i < 32; i++)
    begin
      current_instr_address = 32'h0000_2000 + 32'(i * 8);
      runBranch(5'h0C, i[4:0], i[0]);
      runBranch(5'h04, i[4:0], ~i[0]);
      runBranch(5'h0D, i[4:0], 1'h0);
    end
  endtask : testConditional
  // a word with another extended opcode neither branches nor links
  task automatic testNonHit();
    current_instr_address = 32'h0000_3000;
    runBranch(5'h14, 5'h00, 1'h1);
    issue(5'h14, 5'h00, 1'h1, 10'h010);
    check("hit", hit, 32'h0);
    check("next", next_instr_address, current_instr_address + 32'h4);
    check("linkWrite", linkWr, 32'h0);
    instrValid = 0;
    @(posedge clk);
    #1;
    check("linkReg", lr, current_instr_address + 32'h4);
  endtask : testNonHit
  // a low enable holds every output while new words arrive
  task automatic testFreeze();
    cr = 32'h0000_0000;
    ctr = 32'h0000_4441;
    current_instr_address = 32'h0000_5000;
    runBranch(5'h14, 5'h00, 1'h1);
    clkEn = 0;
    current_instr_address = 32'h0000_6000;
    issue(5'h04, 5'h01, 1'h0, 10'h210);
    check("frozenValid", resultValid, 32'h1);
    check("frozenTaken", taken, 32'h1);
    check("frozenNext", next_instr_address, {ctr[31:2], 2'h0});
    check("frozenLinkWrite", linkWr, 32'h1);
    check("frozenLinkData", linkData, 32'h0000_5004);
    ctr = 32'h0000_8882;
    clkEn = 1;
    runBranch(5'h04, 5'h01, 1'h0);
  endtask : testFreeze
  // reset in mid-run clears every output and the far-side link register
  task automatic testMidReset();
    current_instr_address = 32'h0000_7000;
    runBranch(5'h14, 5'h00, 1'h1);
    rst_b = 0;
    #1;
    check("resetValid", resultValid, 32'h0);
    check("resetNext", next_instr_address, 32'h0);
    check("resetLinkData", linkData, 32'h0);
    check("resetLinkReg", lr, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1;
    runBranch(5'h14, 5'h02, 1'h0);
    check("linkRegAfterReset", lr, 32'h0);
  endtask : testMidReset
  task automatic finishTest();
    if (nErrors == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finishTest
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1;
    testUnconditional();
    testConditional();
    testNonHit();
    testFreeze();
    testMidReset();
    finishTest();
  end
endmodule : tb_top
